// ---- occ_channel.sv ----
// one output channel: override, enable, logic type, unlatch and on/off delays
`timescale 1ns/100ps
`default_nettype none
module occ_channel (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic ctrl_used,
    input wire logic ctrl_on,
    input wire logic en_used,
    input wire logic en_on,
    input wire logic ovr_used,
    input wire logic ovr_on,
    input wire logic unl_used,
    input wire logic unl_on,
    input wire logic [2:0] logic_type,
    input wire logic [2:0] en_resp,
    input wire logic ovr_resp,
    input wire logic ovr_state,
    input wire logic dly_en,
    input wire logic [15:0] on_dly,
    input wire logic [15:0] off_dly,
    input wire logic [15:0] toggle_ms,
    output logic ovr_act,
    output logic state
);
    logic ctrl_prev_q, latch_q, toggle_q, state_q;
    logic [15:0] tog_cnt_q, dly_cnt_q, dly_need;
    logic rise, fall, logic_val, follow, hold, target, dly_done;

    assign rise = ctrl_on && !ctrl_prev_q;
    assign fall = !ctrl_on && ctrl_prev_q;
    assign ovr_act = ovr_used && (ovr_on == ovr_resp);

    always_comb begin
        unique case (logic_type)
            occ_pkg::LT_NORMAL: logic_val = ctrl_on;
            occ_pkg::LT_INVERSE: logic_val = !ctrl_on;
            occ_pkg::LT_LATCH, occ_pkg::LT_INV_LATCH: logic_val = latch_q;
            occ_pkg::LT_TOGGLE: logic_val = ctrl_on && toggle_q;
            default: logic_val = 1'b0;
        endcase
    end

    always_comb begin
        follow = 1'b1;
        hold = 1'b0;
        if (en_used) begin
            unique case (en_resp)
                occ_pkg::ER_EN_ON, occ_pkg::ER_DIS_OFF: follow = en_on;
                occ_pkg::ER_EN_OFF, occ_pkg::ER_DIS_ON: follow = !en_on;
                occ_pkg::ER_EN_ON_KEEP: begin
                    follow = en_on;
                    hold = !en_on;
                end
                occ_pkg::ER_EN_OFF_KEEP: begin
                    follow = !en_on;
                    hold = en_on;
                end
                default: follow = 1'b0;
            endcase
        end
    end

    // unused control forces off first, then override, then enable, then control, unlatch acts inside the latch
    assign target = !ctrl_used ? 1'b0 : ovr_act ? ovr_state : follow ? logic_val : hold && state_q;
    assign dly_need = target ? on_dly : off_dly;
    assign dly_done = !dly_en || ovr_act || !ctrl_used || dly_cnt_q >= dly_need;
    assign state = state_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_prev_q <= 1'b0;
            latch_q <= 1'b0;
            toggle_q <= 1'b0;
            tog_cnt_q <= 16'h0000;
        end else if (tick) begin
            ctrl_prev_q <= ctrl_on;
            if (unl_used && unl_on) begin
                latch_q <= 1'b0;
            end else if ((logic_type == occ_pkg::LT_LATCH && rise) ||
                         (logic_type == occ_pkg::LT_INV_LATCH && fall)) begin
                latch_q <= 1'b1;
            end
            if (!ctrl_on || toggle_ms == 16'h0000) begin
                toggle_q <= 1'b0;
                tog_cnt_q <= 16'h0000;
            end else if (tog_cnt_q + 16'h0001 >= toggle_ms) begin
                toggle_q <= !toggle_q;
                tog_cnt_q <= 16'h0000;
            end else begin
                tog_cnt_q <= tog_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= 1'b0;
            dly_cnt_q <= 16'h0000;
        end else if (tick) begin
            if (target == state_q) begin
                dly_cnt_q <= 16'h0000;
            end else if (dly_done) begin
                state_q <= target;
                dly_cnt_q <= 16'h0000;
            end else begin
                dly_cnt_q <= dly_cnt_q + 16'h0001;
            end
        end
    end
endmodule // occ_channel
`default_nettype wire

// ---- occ_load_model.sv ----
// actuator load: relay contact that follows the interlock pin
`timescale 1ns/100ps
`default_nettype none
module occ_load_model (
    input wire logic core_clk,
    input wire logic drive,
    output logic closed_q
);
    always_ff @(posedge core_clk) begin
        closed_q <= drive;
    end
endmodule // occ_load_model
`default_nettype wire

// ---- occ_output_control.sv ----
// top of the output channel control: registers, control tick, channels, analog path
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - output type 0 disabled, 1 digital, 2 voltage, 3 current.
// - combined output is digital or analog, never both at once.
// - range code 0/1 voltage 0-5/0-10 V; current 0/1/2 4-20/0-20/0-24 mA.
// - slew step and slew clock only apply while slew limiting is enabled.
// - analog level follows control source, scaled from its range to output range.
// - override wins over enable, enable over control, control over unlatch; here an active unlatch clears the latch even on a latching control edge.
// - output stays off unless its control source is used, except an active override on the analog level.
// - source selector codes 0..11 choose a class, each with its own index range.
// - any function block result may drive any block, the outputs included.
// - override response 0 acts on source off, 1 on source on; drives override value.
// - interlock override state 0 forces contact open, 1 forces it closed.
// - six enable responses, codes 0 through 5.
// - responses 0 and 3 follow control while enable on, else off.
// - responses 1 and 2 follow control while enable off, else off.
// - response 4 follows while enable on, keeps state while off.
// - response 5 follows while enable off, keeps state while on.
// - optional turn-on and turn-off delays for enable and control changes.
// - two channels, combined digital/analog and interlock without analog.
// - latched logic sets on rising control, inverse latched on falling.
// - active unlatch clears the latch; it stays off until next latching edge.
module occ_output_control #(
    parameter int unsigned TICK_CYC = occ_pkg::TICK_CYC,
    parameter int unsigned NUM_SRC = occ_pkg::NUM_SRC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [NUM_SRC*16-1:0] fb_values,
    output logic da_digital_out,
    output logic [15:0] da_level,
    output logic da_voltage_mode,
    output logic da_current_mode,
    output logic il_out
);
    localparam int unsigned NCH = occ_pkg::NUM_CH;
    localparam int unsigned NREG = occ_pkg::CH_REGS;

    // register storage
    logic [15:0] ch_reg_q [NCH][NREG];
    logic [15:0] out_cfg_q, slew_step_q, slew_clk_q, src_min_q, src_max_q;
    logic [15:0] rdata_q;

    // bus decode
    logic [3:0] ch_sel, reg_idx;
    logic ch_hit, g_hit;
    logic [15:0] ch_rd, g_rd, rd_mux;

    assign ch_sel = reg_addr[7:4];
    assign reg_idx = reg_addr[3:0];
    assign ch_hit = ({28'h0, ch_sel} < NCH) && ({28'h0, reg_idx} < NREG);
    assign ch_rd = ch_hit ? ch_reg_q[ch_sel[0]][reg_idx] : 16'h0000;

    // control tick
    logic [31:0] tick_cnt_q;
    logic tick_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYC - 1) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // configuration fields
    logic [1:0] out_type, out_range;
    logic slew_en, type_digital, type_analog;

    assign out_type = out_cfg_q[occ_pkg::CFG_TYPE_LSB +: 2];
    assign out_range = out_cfg_q[occ_pkg::CFG_RANGE_LSB +: 2];
    assign slew_en = out_cfg_q[occ_pkg::CFG_SLEW_BIT];
    assign type_digital = out_type == occ_pkg::OT_DIGITAL;
    assign type_analog = out_type == occ_pkg::OT_VOLTAGE || out_type == occ_pkg::OT_CURRENT;

    // per-channel sources and channel logic
    logic [15:0] src_val [NCH][4];
    logic src_used [NCH][4];
    logic src_on [NCH][4];
    logic ch_state [NCH];
    logic ch_ovr [NCH];
    logic ch_ovr_state [NCH];

    // channel 0 is the combined output, channel 1 the interlock
    assign ch_ovr_state[0] = ch_reg_q[0][occ_pkg::REG_OVR_VAL] != 16'h0000;
    assign ch_ovr_state[1] = ch_reg_q[1][occ_pkg::REG_OVR_VAL][0];

    genvar c, r;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic [15:0] mode;
            logic ctrl_gate;

            for (r = 0; r < 4; r++) begin : g_src
                occ_src_mux #(
                    .NUM_SRC(NUM_SRC),
                    .W(16)
                ) u_mux (
                    .fb_values(fb_values),
                    .src_class(ch_reg_q[c][r][occ_pkg::SRC_CLASS_LSB +: 4]),
                    .src_index(ch_reg_q[c][r][occ_pkg::SRC_IDX_LSB +: 4]),
                    .value(src_val[c][r]),
                    .used(src_used[c][r]),
                    .on(src_on[c][r])
                );
            end

            assign mode = ch_reg_q[c][occ_pkg::REG_MODE];
            // a disabled combined output never acts
            assign ctrl_gate = src_used[c][0] && (c != 0 || out_type != occ_pkg::OT_DISABLED);

            occ_channel u_ch (
                .core_clk(core_clk),
                .rst(rst),
                .tick(tick_q),
                .ctrl_used(ctrl_gate),
                .ctrl_on(src_on[c][0]),
                .en_used(src_used[c][1]),
                .en_on(src_on[c][1]),
                .ovr_used(src_used[c][2]),
                .ovr_on(src_on[c][2]),
                .unl_used(src_used[c][3]),
                .unl_on(src_on[c][3]),
                .logic_type(mode[occ_pkg::MODE_LOGIC_LSB +: 3]),
                .en_resp(mode[occ_pkg::MODE_EN_LSB +: 3]),
                .ovr_resp(mode[occ_pkg::MODE_OVR_RESP_BIT]),
                .ovr_state(ch_ovr_state[c]),
                .dly_en(mode[occ_pkg::MODE_DLY_BIT]),
                .on_dly(ch_reg_q[c][occ_pkg::REG_ON_DLY]),
                .off_dly(ch_reg_q[c][occ_pkg::REG_OFF_DLY]),
                .toggle_ms(ch_reg_q[c][occ_pkg::REG_TOGGLE]),
                .ovr_act(ch_ovr[c]),
                .state(ch_state[c])
            );
        end
    endgenerate

    // analog range end points
    logic [15:0] out_lo, out_hi;

    always_comb begin
        out_lo = 16'h0000;
        out_hi = 16'h0000;
        if (out_type == occ_pkg::OT_VOLTAGE) begin
            out_lo = occ_pkg::V_LO;
            if (out_range == 2'h0) begin
                out_hi = occ_pkg::V5_HI;
            end else if (out_range == 2'h1) begin
                out_hi = occ_pkg::V10_HI;
            end
        end else if (out_type == occ_pkg::OT_CURRENT) begin
            if (out_range == 2'h0) begin
                out_lo = occ_pkg::I4_LO;
                out_hi = occ_pkg::I20_HI;
            end else if (out_range == 2'h1) begin
                out_hi = occ_pkg::I20_HI;
            end else if (out_range == 2'h2) begin
                out_hi = occ_pkg::I24_HI;
            end
        end
    end

    // scale control value from source range to output range
    logic [15:0] sval, sval_c, span_in, scaled, ana_tgt;
    logic [31:0] num, quo;

    assign sval = src_val[0][0];
    assign sval_c = sval < src_min_q ? src_min_q : (sval > src_max_q ? src_max_q : sval);
    assign span_in = src_max_q > src_min_q ? src_max_q - src_min_q : 16'h0000;
    assign num = {16'h0, sval_c - src_min_q} * {16'h0, out_hi - out_lo};
    assign quo = span_in == 16'h0000 ? 32'h0 : num / {16'h0, span_in};
    assign scaled = out_lo + quo[15:0];

    // override value, scaled source, or range floor when the channel is off
    assign ana_tgt = !type_analog ? 16'h0000 :
                     ch_ovr[0] ? ch_reg_q[0][occ_pkg::REG_OVR_VAL] :
                     ch_state[0] ? scaled : out_lo;

    // slew limiter
    logic [15:0] level_q, slew_cnt_q, diff;
    logic slew_fire, going_up;

    assign going_up = ana_tgt > level_q;
    assign diff = going_up ? ana_tgt - level_q : level_q - ana_tgt;
    assign slew_fire = slew_cnt_q >= slew_clk_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_q <= 16'h0000;
            slew_cnt_q <= 16'h0000;
        end else if (tick_q) begin
            if (!slew_en || !type_analog) begin
                level_q <= ana_tgt;
                slew_cnt_q <= 16'h0000;
            end else if (!slew_fire) begin
                slew_cnt_q <= slew_cnt_q + 16'h0001;
            end else begin
                slew_cnt_q <= 16'h0000;
                if (diff <= slew_step_q) begin
                    level_q <= ana_tgt;
                end else if (going_up) begin
                    level_q <= level_q + slew_step_q;
                end else begin
                    level_q <= level_q - slew_step_q;
                end
            end
        end
    end

    // output pins, digital and analog exclusive
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            da_digital_out <= 1'b0;
            da_level <= 16'h0000;
            da_voltage_mode <= 1'b0;
            da_current_mode <= 1'b0;
            il_out <= 1'b0;
        end else begin
            da_digital_out <= type_digital && ch_state[0];
            da_level <= !type_analog ? 16'h0000 : (level_q > out_hi ? out_hi : level_q);
            da_voltage_mode <= out_type == occ_pkg::OT_VOLTAGE;
            da_current_mode <= out_type == occ_pkg::OT_CURRENT;
            il_out <= ch_state[1];
        end
    end

    // global register read
    logic [15:0] status;

    assign status = {11'h0, level_q != ana_tgt, ch_ovr[1], ch_ovr[0], ch_state[1], ch_state[0]};
    assign g_hit = reg_addr >= occ_pkg::REG_OUT_CFG && reg_addr <= occ_pkg::REG_LEVEL;

    always_comb begin
        unique case (reg_addr)
            occ_pkg::REG_OUT_CFG: g_rd = out_cfg_q;
            occ_pkg::REG_SLEW_STEP: g_rd = slew_step_q;
            occ_pkg::REG_SLEW_CLK: g_rd = slew_clk_q;
            occ_pkg::REG_SRC_MIN: g_rd = src_min_q;
            occ_pkg::REG_SRC_MAX: g_rd = src_max_q;
            occ_pkg::REG_STATUS: g_rd = status;
            occ_pkg::REG_LEVEL: g_rd = level_q;
            default: g_rd = 16'h0000;
        endcase
    end

    assign rd_mux = g_hit ? g_rd : ch_rd;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;

    // channel register writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                for (int j = 0; j < NREG; j++) begin
                    ch_reg_q[i][j] <= (j == int'(occ_pkg::REG_MODE)) ? occ_pkg::MODE_RST : 16'h0000;
                end
            end
        end else if (reg_wr && ch_hit) begin
            ch_reg_q[ch_sel[0]][reg_idx] <= reg_wdata;
        end
    end

    // global register writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_cfg_q <= occ_pkg::OUT_CFG_RST;
            slew_step_q <= 16'h0000;
            slew_clk_q <= 16'h0000;
            src_min_q <= 16'h0000;
            src_max_q <= occ_pkg::SRC_MAX_RST;
        end else if (reg_wr) begin
            if (reg_addr == occ_pkg::REG_OUT_CFG) begin
                out_cfg_q <= reg_wdata;
            end
            if (reg_addr == occ_pkg::REG_SLEW_STEP) begin
                slew_step_q <= reg_wdata;
            end
            if (reg_addr == occ_pkg::REG_SLEW_CLK) begin
                slew_clk_q <= reg_wdata;
            end
            if (reg_addr == occ_pkg::REG_SRC_MIN) begin
                src_min_q <= reg_wdata;
            end
            if (reg_addr == occ_pkg::REG_SRC_MAX) begin
                src_max_q <= reg_wdata;
            end
        end
    end
endmodule // occ_output_control
`default_nettype wire

// ---- occ_output_control_properties.sv ----
// port assertions of the output channel control
`timescale 1ns/100ps
`default_nettype none
module occ_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic da_digital_out,
    input wire logic [15:0] da_level,
    input wire logic da_voltage_mode,
    input wire logic da_current_mode,
    input wire logic il_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_one_mode; !(da_voltage_mode && da_current_mode); endproperty
    a_one_mode: assert property (p_one_mode) else $error("two analog modes");
    property p_dig_alone; da_digital_out |-> !da_voltage_mode && !da_current_mode; endproperty
    a_dig_alone: assert property (p_dig_alone) else $error("digital in analog mode");
    property p_lvl_mode; da_level != 16'h0000 |-> da_voltage_mode || da_current_mode; endproperty
    a_lvl_mode: assert property (p_lvl_mode) else $error("level outside analog");
    property p_v_max; da_voltage_mode |-> da_level <= occ_pkg::V10_HI; endproperty
    a_v_max: assert property (p_v_max) else $error("voltage above range");
    property p_i_max; da_current_mode |-> da_level <= occ_pkg::I24_HI; endproperty
    a_i_max: assert property (p_i_max) else $error("current above range");
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_unmapped; $past(reg_rd) && $past(reg_addr) > 8'h26 |-> reg_rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rst_out; $fell(rst) |-> !il_out && !da_digital_out && !da_voltage_mode; endproperty
    a_rst_out: assert property (p_rst_out) else $error("output on after reset");
endmodule // occ_checker
bind occ_output_control occ_checker u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .da_digital_out(da_digital_out), .da_level(da_level),
    .da_voltage_mode(da_voltage_mode), .da_current_mode(da_current_mode), .il_out(il_out));
`default_nettype wire

// ---- occ_pkg.sv ----
// shared register map, field layout, encodings and timing of the output channel control
package occ_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned NUM_SRC = 58;
    localparam int unsigned NUM_CLASSES = 12;
    // per-channel register block: channel n sits at n * 16
    localparam logic [3:0] REG_CTRL_SRC = 4'h0;
    localparam logic [3:0] REG_EN_SRC = 4'h1;
    localparam logic [3:0] REG_OVR_SRC = 4'h2;
    localparam logic [3:0] REG_UNL_SRC = 4'h3;
    localparam logic [3:0] REG_MODE = 4'h4;
    localparam logic [3:0] REG_OVR_VAL = 4'h5;
    localparam logic [3:0] REG_ON_DLY = 4'h6;
    localparam logic [3:0] REG_OFF_DLY = 4'h7;
    localparam logic [3:0] REG_TOGGLE = 4'h8;
    localparam int unsigned CH_REGS = 9;
    // global registers
    localparam logic [7:0] REG_OUT_CFG = 8'h20;
    localparam logic [7:0] REG_SLEW_STEP = 8'h21;
    localparam logic [7:0] REG_SLEW_CLK = 8'h22;
    localparam logic [7:0] REG_SRC_MIN = 8'h23;
    localparam logic [7:0] REG_SRC_MAX = 8'h24;
    localparam logic [7:0] REG_STATUS = 8'h25;
    localparam logic [7:0] REG_LEVEL = 8'h26;
    // source selector fields
    localparam int unsigned SRC_CLASS_LSB = 0;
    localparam int unsigned SRC_IDX_LSB = 4;
    // mode fields
    localparam int unsigned MODE_LOGIC_LSB = 0;
    localparam int unsigned MODE_EN_LSB = 3;
    localparam int unsigned MODE_OVR_RESP_BIT = 6;
    localparam int unsigned MODE_DLY_BIT = 7;
    // output configuration fields
    localparam int unsigned CFG_TYPE_LSB = 0;
    localparam int unsigned CFG_RANGE_LSB = 2;
    localparam int unsigned CFG_SLEW_BIT = 4;
    // reset values
    localparam logic [15:0] MODE_RST = 16'h0001;
    localparam logic [15:0] OUT_CFG_RST = 16'h0001;
    localparam logic [15:0] SRC_MAX_RST = 16'hffff;
    // output types
    localparam logic [1:0] OT_DISABLED = 2'h0;
    localparam logic [1:0] OT_DIGITAL = 2'h1;
    localparam logic [1:0] OT_VOLTAGE = 2'h2;
    localparam logic [1:0] OT_CURRENT = 2'h3;
    // logic types
    localparam logic [2:0] LT_NONE = 3'h0;
    localparam logic [2:0] LT_NORMAL = 3'h1;
    localparam logic [2:0] LT_INVERSE = 3'h2;
    localparam logic [2:0] LT_LATCH = 3'h3;
    localparam logic [2:0] LT_INV_LATCH = 3'h4;
    localparam logic [2:0] LT_TOGGLE = 3'h5;
    // enable responses
    localparam logic [2:0] ER_EN_ON = 3'h0;
    localparam logic [2:0] ER_EN_OFF = 3'h1;
    localparam logic [2:0] ER_DIS_ON = 3'h2;
    localparam logic [2:0] ER_DIS_OFF = 3'h3;
    localparam logic [2:0] ER_EN_ON_KEEP = 3'h4;
    localparam logic [2:0] ER_EN_OFF_KEEP = 3'h5;
    // analog range end points, millivolts or microamps
    localparam logic [15:0] V_LO = 16'h0000;
    localparam logic [15:0] V5_HI = 16'h1388;
    localparam logic [15:0] V10_HI = 16'h2710;
    localparam logic [15:0] I4_LO = 16'h0fa0;
    localparam logic [15:0] I20_HI = 16'h4e20;
    localparam logic [15:0] I24_HI = 16'h5dc0;
    // control tick
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // entries in each source class
    function automatic logic [5:0] class_size(input logic [3:0] c);
        unique case (c)
            4'h1, 4'h2, 4'h3, 4'h7: class_size = 6'h04;
            4'h4: class_size = 6'h01;
            4'h5: class_size = 6'h05;
            4'h6: class_size = 6'h0f;
            4'h8: class_size = 6'h02;
            4'h9: class_size = 6'h06;
            4'ha: class_size = 6'h0a;
            4'hb: class_size = 6'h03;
            default: class_size = 6'h00;
        endcase
    endfunction

    // first flat position of each source class
    function automatic logic [5:0] class_base(input logic [3:0] c);
        unique case (c)
            4'h2: class_base = 6'h04;
            4'h3: class_base = 6'h08;
            4'h4: class_base = 6'h0c;
            4'h5: class_base = 6'h0d;
            4'h6: class_base = 6'h12;
            4'h7: class_base = 6'h21;
            4'h8: class_base = 6'h25;
            4'h9: class_base = 6'h27;
            4'ha: class_base = 6'h2d;
            4'hb: class_base = 6'h37;
            default: class_base = 6'h00;
        endcase
    endfunction
endpackage

// ---- occ_src_mux.sv ----
// selects one function block result by source class and 1-based index
`timescale 1ns/100ps
`default_nettype none
module occ_src_mux #(
    parameter int unsigned NUM_SRC = occ_pkg::NUM_SRC,
    parameter int unsigned W = occ_pkg::DATA_W
) (
    input wire logic [NUM_SRC*W-1:0] fb_values,
    input wire logic [3:0] src_class,
    input wire logic [3:0] src_index,
    output logic [W-1:0] value,
    output logic used,
    output logic on
);
    logic [5:0] size;
    logic [5:0] flat;
    logic in_range;

    assign size = occ_pkg::class_size(src_class);
    assign used = size != 6'h00;
    assign in_range = used && src_index != 4'h0 && {2'h0, src_index} <= size;
    assign flat = occ_pkg::class_base(src_class) + {2'h0, src_index} - 6'h01;
    // any result of the flat table may feed any consumer
    assign value = in_range ? fb_values[flat*W +: W] : '0;
    assign on = value != '0;
endmodule // occ_src_mux
`default_nettype wire

// ---- tb.sv ----
// self-checking bench of the output channel control
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int TC = 4;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, da_level, r;
    logic [occ_pkg::NUM_SRC*16-1:0] fb_values = '0;
    logic da_digital_out, da_voltage_mode, da_current_mode, il_out, closed_q, en, ct, st;
    logic [3:0] cfgs [5] = '{4'h2, 4'h6, 4'h3, 4'h7, 4'hb};
    int mismatches = 0, compares = 0;
    int seed = 32'h4cd4;
    always #10 core_clk = ~core_clk;
    occ_output_control #(.TICK_CYC(TC)) u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fb_values(fb_values),
        .da_digital_out(da_digital_out), .da_level(da_level), .da_voltage_mode(da_voltage_mode),
        .da_current_mode(da_current_mode), .il_out(il_out));
    occ_load_model u_load (.core_clk(core_clk), .drive(il_out), .closed_q(closed_q));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata, exp, "reg_rdata");
        @(posedge core_clk);
    endtask
    task automatic ticks(input int n);
        repeat (n * TC) @(posedge core_clk);
    endtask
    function automatic logic follow(input logic [2:0] er, input logic e, input logic c, input logic p);
        case (er)
            3'h0, 3'h3: follow = e & c;
            3'h1, 3'h2: follow = ~e & c;
            3'h4: follow = e ? c : p;
            default: follow = ~e ? c : p;
        endcase
    endfunction
    function automatic logic [15:0] scale(input logic [3:0] cfg, input logic [15:0] v);
        logic [15:0] lo, hi;
        lo = (cfg == 4'h3) ? occ_pkg::I4_LO : 16'h0000;
        case (cfg)
            4'h2: hi = occ_pkg::V5_HI;
            4'h6: hi = occ_pkg::V10_HI;
            4'h3, 4'h7: hi = occ_pkg::I20_HI;
            default: hi = occ_pkg::I24_HI;
        endcase
        scale = lo + 16'((32'(v) * (hi - lo)) / 32'hffff);
    endfunction
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(8'h04, occ_pkg::MODE_RST);
        rd(8'h20, occ_pkg::OUT_CFG_RST);
        rd(8'h24, occ_pkg::SRC_MAX_RST);
        rd(8'h7f, 16'h0000);
        fb_values[18*16 +: 16] <= 16'h0001;
        ticks(3);
        check(da_digital_out, 16'h0000, "unused source");
        wr(8'h00, 16'h0016);
        wr(8'h10, 16'h0016);
        wr(8'h11, 16'h0026);
        ticks(3);
        check(da_digital_out, 16'h0001, "digital out");
        $display("select done");
        en = 1'b0;
        ct = 1'b1;
        st = 1'b0;
        for (int er = 0; er < 6; er++) begin
            wr(8'h14, {10'h000, er[2:0], 3'h1});
            ticks(1);
            st = follow(er[2:0], en, ct, st);
            repeat (6) begin
                en = 1'($random(seed));
                ct = 1'($random(seed));
                fb_values[18*16 +: 16] <= {15'h0000, ct};
                fb_values[19*16 +: 16] <= {15'h0000, en};
                ticks(3);
                st = follow(er[2:0], en, ct, st);
                check(il_out, st, "il_out");
                check(closed_q, st, "contact");
            end
        end
        $display("enable done");
        wr(8'h12, 16'h0036);
        wr(8'h14, 16'h0041);
        for (int v = 0; v < 2; v++) begin
            wr(8'h15, {15'h0000, v[0]});
            fb_values[18*16 +: 16] <= {15'h0000, ~v[0]};
            fb_values[19*16 +: 16] <= 16'h0001;
            fb_values[20*16 +: 16] <= 16'h0001;
            ticks(3);
            check(il_out, {15'h0000, v[0]}, "override");
        end
        $display("override done");
        foreach (cfgs[i]) begin
            r = 16'($random(seed)) | 16'h0001;
            fb_values[18*16 +: 16] <= r;
            wr(8'h20, {12'h000, cfgs[i]});
            ticks(3);
            check(da_level, scale(cfgs[i], r), "da_level");
            check(da_voltage_mode, {15'h0000, ~cfgs[i][0]}, "voltage mode");
            check(da_current_mode, {15'h0, cfgs[i][0]}, "current");
            check(da_digital_out, 16'h0000, "digital in analog");
            rd(8'h26, scale(cfgs[i], r));
        end
        $display("analog done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
